// ==== src/rtc_port_params.svh ====
`ifndef RTC_PORT_PARAMS_SVH
`define RTC_PORT_PARAMS_SVH
// Clock and timing
`define RTC_CLK_PERIOD_NS   10
`define RTC_RECOVERY_NS     1000000
// Register space
`define RTC_NUM_REGS        32
`define RTC_TIME_BYTES      8
`define RTC_FIFO_DEPTH      16
// Command byte fields
`define RTC_CMD_DIR_BIT     7
// Time byte fields and reset values
`define RTC_STOP_BIT        7
`define RTC_CENT_LSB        6
`define RTC_DAY_RESET       8'h01
`define RTC_DATE_RESET      8'h01
`define RTC_MONTH_RESET     8'h01
`endif

// ==== src/rtc_port_pkg.sv ====
package rtc_port_pkg;
  // Serial engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ  = 2'b11
  } port_state_t;
  // One committed byte on its way to the register file
  typedef struct packed {
    logic [4:0] idx;
    logic [7:0] data;
  } wr_word_t;
  // Eight timekeeping bytes, index 0 is hundredths
  typedef logic [7:0][7:0] time_bytes_t;
endpackage

// ==== src/rtc_wr_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_wr_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             in_ready_out,
  // Drain side
  output var  logic             out_valid_out,
  output var  logic [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty = (wr_ptr_reg == rd_ptr_reg);
  wire              push  = in_valid_in & ~full;
  wire              pop   = out_ready_in & ~empty;
  // Flags from pointers only
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  // Pointers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== src/rtc_time_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_port_params.svh"
module rtc_time_counter (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  // Hundredths timebase
  input  wire logic                      tick_in,
  // Byte write
  input  wire logic                      wr_valid_in,
  input  wire logic [2:0]                wr_idx_in,
  input  wire logic [7:0]                wr_data_in,
  // Running time
  output var  rtc_port_pkg::time_bytes_t time_out
);
  import rtc_port_pkg::*;
  time_bytes_t t_reg;
  time_bytes_t t_next;
  // BCD increment
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  // Month length, leap years by BCD digits
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction
  // Carry chain, stop bit halts counting
  wire       c0 = tick_in & ~t_reg[1][`RTC_STOP_BIT];
  wire       c1 = c0 & (t_reg[0] == 8'h99);
  wire       c2 = c1 & (t_reg[1][6:0] == 7'h59);
  wire       c3 = c2 & (t_reg[2][6:0] == 7'h59);
  wire       c4 = c3 & (t_reg[3][5:0] == 6'h23);
  wire       c5 = c4 & (t_reg[5] == month_len(t_reg[6], t_reg[7]));
  wire       c6 = c5 & (t_reg[6] == 8'h12);
  wire       c7 = c6 & (t_reg[7] == 8'h99);
  wire [1:0] cent = t_reg[3][7:`RTC_CENT_LSB] + 2'(c7);
  always_comb begin
    t_next    = t_reg;
    t_next[0] = c1 ? 8'h00 : (c0 ? bcd_inc(t_reg[0]) : t_reg[0]);
    if (c1) t_next[1][6:0] = c2 ? 7'h00 : 7'(bcd_inc({1'b0, t_reg[1][6:0]}));
    if (c2) t_next[2][6:0] = c3 ? 7'h00 : 7'(bcd_inc({1'b0, t_reg[2][6:0]}));
    if (c3) t_next[3][5:0] = c4 ? 6'h00 : 6'(bcd_inc({2'b00, t_reg[3][5:0]}));
    t_next[3][7:`RTC_CENT_LSB] = cent;
    if (c4) t_next[4][2:0] = (t_reg[4][2:0] == 3'h7) ? 3'h1 : t_reg[4][2:0] + 3'h1;
    if (c4) t_next[5] = c5 ? 8'h01 : bcd_inc(t_reg[5]);
    if (c5) t_next[6] = c6 ? 8'h01 : bcd_inc(t_reg[6]);
    if (c6) t_next[7] = c7 ? 8'h00 : bcd_inc(t_reg[7]);
    if (wr_valid_in) t_next[wr_idx_in] = wr_data_in;
  end
  // Counter state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      t_reg    <= '0;
      t_reg[4] <= `RTC_DAY_RESET;
      t_reg[5] <= `RTC_DATE_RESET;
      t_reg[6] <= `RTC_MONTH_RESET;
    end else begin
      t_reg <= t_next;
    end
  end
  assign time_out = t_reg;
endmodule
`default_nettype wire

// ==== src/rtc_serial_register_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_port_params.svh"
// Contract
// - Serial input bits are captured on rising serial clock edges.
// - Serial output changes after each falling serial clock edge.
// - Select high: ignore clock and data, output undriven.
// - Everything most significant bit first, from first rising edge after select.
// - Read output stays undriven until a whole byte is ready.
// - Pointer advances by one after every data byte.
// - Thirty-two byte locations in fixed order, time bytes first.
// - Eight time bytes, seventeen control bytes, seven user bytes.
// - Time bytes are BCD, hours on a 24-hour scale.
// - Date rolls over for 28, 29, 30, 31 day months.
// - Low supply aborts transfer, clears pointer, ignores inputs.
// - Writes stay blocked until power-fail level plus recovery period.
// - First bit is direction, one writes; then seven address bits.
// - Address bit 6 is ignored for decoding.
// - Pointer wraps from 3Fh to 00h while selected.
// - Time copy freezes while pointer addresses a time byte; the code freezes it only in the read or write data phase.
module rtc_serial_register_port #(
  parameter int RECOVERY_NS = `RTC_RECOVERY_NS,
  parameter int FIFO_DEPTH  = `RTC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  // Serial link pins
  input  wire logic                      serial_clk_in,
  input  wire logic                      select_n_in,
  input  wire logic                      serial_in_pin_in,
  output var  logic                      serial_out_pin_out,
  output var  logic                      serial_out_pin_oe_out,
  // Supply monitor
  input  wire logic                      below_reset_threshold_in,
  input  wire logic                      above_power_fail_level_in,
  // Hundredths timebase
  input  wire logic                      hundredths_tick_in,
  // Status
  output var  logic                      write_blocked_out,
  output var  rtc_port_pkg::time_bytes_t time_view_out
);
  import rtc_port_pkg::*;

  localparam int NREG       = `RTC_NUM_REGS;
  localparam int NTIME      = `RTC_TIME_BYTES;
  // Least time rounds up to whole cycles
  localparam int REC_CYCLES = (RECOVERY_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS;

  // Refuse values the logic cannot serve
  if (REC_CYCLES < 1) begin : g_chk_rec
    $error("recovery period must be at least one cycle");
  end
  if (FIFO_DEPTH < 2) begin : g_chk_fifo
    $error("fifo depth too small");
  end

  // Index of a register from a pointer
  function automatic logic [4:0] reg_index(input logic [6:0] addr);
    reg_index = addr[4:0];
  endfunction

  // Pointer lands on a time byte
  function automatic logic is_time(input logic [6:0] addr);
    is_time = (reg_index(addr) < 5'(NTIME));
  endfunction

  // Synchronisers: clock, select, data, below, above
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic        sck_d_reg;
  logic        seln_d_reg;

  // Serial engine
  port_state_t state_reg;
  port_state_t state_next;
  logic [2:0]  bit_cnt_reg;
  logic [2:0]  bit_cnt_next;
  logic [7:0]  in_sh_reg;
  logic [7:0]  in_sh_next;
  logic [6:0]  ptr_reg;
  logic [6:0]  ptr_next;
  logic [7:0]  out_sh_reg;
  logic [7:0]  out_sh_next;
  logic        sdo_reg;
  logic        sdo_next;
  logic        oe_reg;
  logic        oe_next;

  // Pending committed byte
  logic        pend_valid_reg;
  wr_word_t    pend_word_reg;

  // Write blocking after supply loss
  logic        wp_reg;
  logic [31:0] rec_cnt_reg;

  // Register file and time copy
  logic [7:0]  regs_reg [NREG];
  time_bytes_t time_now;

  // FIFO hookup
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  wr_word_t    fifo_out_word;
  logic        drain_ready;

  // Synchronised pins
  wire         sck_s   = sync2_reg[0];
  wire         seln_s  = sync2_reg[1];
  wire         sdi_s   = sync2_reg[2];
  wire         below_s = sync2_reg[3];
  wire         above_s = sync2_reg[4];

  // Edge detection on synchronised levels only
  wire         sck_rise = ~sck_d_reg & sck_s;
  wire         sck_fall = sck_d_reg & ~sck_s;
  wire         sel_fall = seln_d_reg & ~seln_s;

  // Command byte decode
  wire [7:0]   cmd_byte  = {in_sh_reg[6:0], sdi_s};
  wire         cmd_write = cmd_byte[`RTC_CMD_DIR_BIT];
  wire [6:0]   ptr_inc   = {1'b0, ptr_reg[5:0] + 6'h01};
  wire         byte_done = sck_rise & (bit_cnt_reg == 3'h7);
  wire [7:0]   rd_byte   = regs_reg[reg_index(ptr_reg)];

  // Freeze while on a time byte
  wire         in_xfer   = (state_reg == ST_WRITE) || (state_reg == ST_READ);
  wire         freeze    = in_xfer & is_time(ptr_reg);

  // Two flip-flops before any logic reads a pin
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {above_power_fail_level_in, below_reset_threshold_in,
                    serial_in_pin_in, select_n_in, serial_clk_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Select taken as low in reset, so a fall needs a high first
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sck_d_reg  <= 1'b0;
      seln_d_reg <= 1'b0;
    end else begin
      sck_d_reg  <= sck_s;
      seln_d_reg <= seln_s;
    end
  end

  // Serial engine next state
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    in_sh_next   = in_sh_reg;
    ptr_next     = ptr_reg;
    out_sh_next  = out_sh_reg;
    sdo_next     = sdo_reg;
    oe_next      = oe_reg;
    if (below_s) begin
      state_next   = ST_IDLE;
      bit_cnt_next = 3'h0;
      ptr_next     = 7'h00;
      oe_next      = 1'b0;
    end else if (seln_s) begin
      state_next   = ST_IDLE;
      bit_cnt_next = 3'h0;
      oe_next      = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Only a select fall starts work
          if (sel_fall) begin
            state_next   = ST_CMD;
            bit_cnt_next = 3'h0;
          end
        end
        ST_CMD: begin
          if (sck_rise) begin
            in_sh_next   = cmd_byte;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              ptr_next   = cmd_byte[6:0];
              state_next = cmd_write ? ST_WRITE : ST_READ;
            end
          end
        end
        ST_WRITE: begin
          if (sck_rise) begin
            in_sh_next   = cmd_byte;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) ptr_next = ptr_inc;
          end
        end
        ST_READ: begin
          if (sck_fall) begin
            bit_cnt_next = bit_cnt_reg + 3'h1;
            // Drive only once a full byte is loaded
            oe_next      = 1'b1;
            if (bit_cnt_reg == 3'h0) begin
              sdo_next    = rd_byte[7];
              out_sh_next = {rd_byte[6:0], 1'b0};
            end else begin
              sdo_next    = out_sh_reg[7];
              out_sh_next = {out_sh_reg[6:0], 1'b0};
            end
            if (bit_cnt_reg == 3'h7) ptr_next = ptr_inc;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Serial engine state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      in_sh_reg   <= 8'h00;
      ptr_reg     <= 7'h00;
      out_sh_reg  <= 8'h00;
      sdo_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      in_sh_reg   <= in_sh_next;
      ptr_reg     <= ptr_next;
      out_sh_reg  <= out_sh_next;
      sdo_reg     <= sdo_next;
      oe_reg      <= oe_next;
    end
  end

  // Commit a complete byte; a full FIFO holds it here
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pend_valid_reg <= 1'b0;
      pend_word_reg  <= '0;
    end else begin
      if (pend_valid_reg && fifo_in_ready) pend_valid_reg <= 1'b0;
      if (state_reg == ST_WRITE && byte_done && !seln_s && !below_s && !wp_reg &&
          (!pend_valid_reg || fifo_in_ready)) begin
        pend_valid_reg     <= 1'b1;
        pend_word_reg.idx  <= reg_index(ptr_reg);
        pend_word_reg.data <= cmd_byte;
      end
    end
  end

  // Hold writes off until level and period both met
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wp_reg      <= 1'b0;
      rec_cnt_reg <= 32'h0;
    end else if (below_s) begin
      wp_reg      <= 1'b1;
      rec_cnt_reg <= 32'h0;
    end else if (wp_reg) begin
      if (!above_s) begin
        rec_cnt_reg <= 32'h0;
      end else if (rec_cnt_reg == 32'(REC_CYCLES - 1)) begin
        wp_reg      <= 1'b0;
        rec_cnt_reg <= 32'h0;
      end else begin
        rec_cnt_reg <= rec_cnt_reg + 32'h1;
      end
    end
  end

  // Drain stalls on a tick so a time write never meets a count
  assign drain_ready = ~hundredths_tick_in;

  // Written bytes buffered toward the register file
  rtc_wr_fifo #(
    .WIDTH ($bits(wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (pend_valid_reg),
    .in_data_in    (pend_word_reg),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_word),
    .out_ready_in  (drain_ready)
  );

  wire drain_go   = fifo_out_valid & drain_ready;
  wire drain_time = drain_go & (fifo_out_word.idx < 5'(NTIME));

  // Running BCD time behind the visible bytes
  rtc_time_counter u_time (
    .clk_in      (sys_clk_in),
    .rst_in      (rst_in),
    .tick_in     (hundredths_tick_in),
    .wr_valid_in (drain_time),
    .wr_idx_in   (fifo_out_word.idx[2:0]),
    .wr_data_in  (fifo_out_word.data),
    .time_out    (time_now)
  );

  // Thirty-two locations, time bytes at 00h..07h
  // Upper bytes are control, status and user storage
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NREG; i++) regs_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NTIME; i++) begin
        if (!freeze) regs_reg[i] <= time_now[i];
      end
      if (drain_go && !drain_time) regs_reg[fifo_out_word.idx] <= fifo_out_word.data;
    end
  end

  // Status outputs from flops
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      write_blocked_out <= 1'b0;
      time_view_out     <= '0;
    end else begin
      write_blocked_out <= wp_reg | below_s;
      for (int i = 0; i < NTIME; i++) time_view_out[i] <= regs_reg[i];
    end
  end

  // Pin drive straight from flops
  assign serial_out_pin_out    = sdo_reg;
  assign serial_out_pin_oe_out = oe_reg;
endmodule
`default_nettype wire

// ==== bench/rtc_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_port_props #(
  parameter int RECOVERY_NS = 100
) (
  // Clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  // Serial link pins
  input  wire logic                      serial_clk_in,
  input  wire logic                      select_n_in,
  input  wire logic                      serial_in_pin_in,
  input  wire logic                      serial_out_pin_out,
  input  wire logic                      serial_out_pin_oe_out,
  // Supply, timebase and status
  input  wire logic                      below_reset_threshold_in,
  input  wire logic                      above_power_fail_level_in,
  input  wire logic                      hundredths_tick_in,
  input  wire logic                      write_blocked_out,
  input  wire rtc_port_pkg::time_bytes_t time_view_out
);
  import rtc_port_pkg::*;
  localparam int REC_CYCLES = RECOVERY_NS / 10;
  logic        sck_q;
  logic [3:0]  edge_cnt;
  logic [7:0]  cmd_sr;
  logic [3:0]  fall_age;
  logic [15:0] hold_cnt;
  // Pin-level edges, seen two samples ahead of the design's sync chain
  wire rise_seen   = serial_clk_in && !sck_q;
  wire fall_seen   = !serial_clk_in && sck_q;
  wire supply_good = above_power_fail_level_in && !below_reset_threshold_in;
  wire frozen_zone = !select_n_in && (edge_cnt == 4'h8) && (cmd_sr[4:0] < 5'h08);
  // Saturating counters keep helper state bounded in long idle spans
  always_ff @(posedge sys_clk_in) begin
    sck_q    <= serial_clk_in;
    fall_age <= (rst_in || fall_seen) ? 4'h0 : ((fall_age == 4'hf) ? fall_age : fall_age + 4'h1);
    hold_cnt <= (rst_in || !supply_good) ? 16'h0 : ((hold_cnt == 16'hffff) ? hold_cnt : hold_cnt + 16'h1);
  end
  // Command capture from the first eight rising edges
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || select_n_in) begin
      edge_cnt <= 4'h0;
      cmd_sr   <= 8'h00;
    end else if (rise_seen && (edge_cnt != 4'hf)) begin
      edge_cnt <= edge_cnt + 4'h1;
      cmd_sr   <= (edge_cnt < 4'h8) ? {cmd_sr[6:0], serial_in_pin_in} : cmd_sr;
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence desel_s;
    select_n_in [*5];
  endsequence
  sequence frozen_s;
    frozen_zone [*6];
  endsequence
  AST_DESEL_OE_OFF: assert property (desel_s |-> !serial_out_pin_oe_out)
    else $error("output enabled while deselected");
  AST_OE_NEEDS_SELECT: assert property ($rose(serial_out_pin_oe_out) |-> !select_n_in && !$past(select_n_in, 3))
    else $error("output enabled without a held select");
  AST_LOW_SUPPLY_OE_OFF: assert property (below_reset_threshold_in [*5] |-> !serial_out_pin_oe_out)
    else $error("output enabled during low supply");
  AST_LOW_SUPPLY_BLOCKS: assert property (below_reset_threshold_in [*5] |-> write_blocked_out)
    else $error("writes not blocked during low supply");
  AST_BLOCK_STAYS: assert property ((write_blocked_out && !above_power_fail_level_in) [*4] |=> write_blocked_out)
    else $error("write block released below power fail level");
  AST_RECOVERY_HOLD: assert property ($fell(write_blocked_out) |-> hold_cnt >= REC_CYCLES)
    else $error("write block released before recovery period");
  AST_OE_AFTER_READ_CMD: assert property ($rose(serial_out_pin_oe_out) |-> edge_cnt >= 4'h8 && !cmd_sr[7])
    else $error("output enabled before a full read command");
  AST_SDO_AFTER_FALL: assert property (serial_out_pin_oe_out && $changed(serial_out_pin_out) |-> fall_age < 4'h6)
    else $error("output bit changed away from a falling edge");
  AST_TIME_FROZEN: assert property (frozen_s |=> $stable(time_view_out))
    else $error("time view moved while pointer on a time byte");
endmodule
bind rtc_serial_register_port rtc_port_props #(.RECOVERY_NS(RECOVERY_NS)) i_rtc_port_props (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in), .select_n_in(select_n_in),
  .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
  .serial_out_pin_oe_out(serial_out_pin_oe_out), .below_reset_threshold_in(below_reset_threshold_in),
  .above_power_fail_level_in(above_power_fail_level_in), .hundredths_tick_in(hundredths_tick_in),
  .write_blocked_out(write_blocked_out), .time_view_out(time_view_out)
);
`default_nettype wire

// ==== bench/rtc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  // Serial link pins toward the device
  output var  logic serial_clk_out,
  output var  logic select_n_out,
  output var  logic serial_in_pin_out,
  input  wire logic serial_out_pin_in
);
  // idle level picks mode 0 or mode 3
  logic cpol = 1'b0;
  // Select starts low so the fresh-fall check has something to refuse
  initial begin
    serial_clk_out    = 1'b0;
    select_n_out      = 1'b0;
    serial_in_pin_out = 1'b0;
  end
  // fresh select fall opens every frame
  task automatic begin_frame();
    #3;
    select_n_out   = 1'b1;
    serial_clk_out = cpol;
    #80;
    select_n_out   = 1'b0;
    #40;
  endtask
  // data set on the fall, held over the rise, MSB first
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      serial_clk_out    = 1'b0;
      serial_in_pin_out = tx[i];
      #40;
      serial_clk_out    = 1'b1;
      // Sampled late in the high phase for margin on the sync chain
      #30;
      rx[i]             = serial_out_pin_in;
      #10;
    end
  endtask
  // Clock stands still between frames; released data line flips
  task automatic end_frame();
    #40;
    serial_clk_out    = cpol;
    #40;
    select_n_out      = 1'b1;
    serial_in_pin_out = ~serial_in_pin_out;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== bench/rtc_serial_register_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_register_port_bench;
  import rtc_port_pkg::*;
  localparam int REC_NS     = 100;
  localparam int REC_CYCLES = REC_NS / 10;
  logic        sys_clk = 1'b0;
  logic        rst, below, above, tick, blocked;
  logic        serial_clk, select_n, serial_in_pin, serial_out_pin, sdo_oe;
  time_bytes_t time_view;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [7:0]  q[$];
  // Pin level: undriven unless the device enables it
  wire         sdo_pin = sdo_oe ? serial_out_pin : 1'bz;
  always #5 sys_clk = ~sys_clk;
  rtc_serial_register_port #(.RECOVERY_NS(REC_NS), .FIFO_DEPTH(16)) i_rtc_serial_register_port (
    .sys_clk_in(sys_clk), .rst_in(rst), .serial_clk_in(serial_clk), .select_n_in(select_n),
    .serial_in_pin_in(serial_in_pin), .serial_out_pin_out(serial_out_pin), .serial_out_pin_oe_out(sdo_oe),
    .below_reset_threshold_in(below), .above_power_fail_level_in(above), .hundredths_tick_in(tick),
    .write_blocked_out(blocked), .time_view_out(time_view));
  rtc_host_model host (
    .serial_clk_out(serial_clk), .select_n_out(select_n), .serial_in_pin_out(serial_in_pin),
    .serial_out_pin_in(sdo_pin));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] addr, input logic [7:0] d[$]);
    logic [7:0] rx;
    host.begin_frame();
    host.xfer({1'b1, addr}, 8, rx);
    foreach (d[i]) host.xfer(d[i], 8, rx);
    host.end_frame();
  endtask
  task automatic rd(input logic [6:0] addr, input int n, output logic [7:0] qo[$]);
    logic [7:0] rx;
    qo = {};
    host.begin_frame();
    host.xfer({1'b0, addr}, 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hc3, 8, rx);
      qo.push_back(rx);
    end
    host.end_frame();
  endtask
  task automatic t_reset_state();
    repeat (3) @(negedge sys_clk);
    chk("oe after reset", 16'h0, {15'h0, sdo_oe});
    chk("date after reset", 16'h01, {8'h0, time_view[5]});
    chk("hundredths after reset", 16'h00, {8'h0, time_view[0]});
    $display("test reset_state done");
  endtask
  // Select low since power-on: a whole write must be ignored
  task automatic t_no_fall();
    logic [7:0] rx;
    host.xfer(8'h98, 8, rx);
    host.xfer(8'h3c, 8, rx);
    host.end_frame();
    rd(7'h18, 1, q);
    chk("write before select fall", 16'h00, {8'h0, q[0]});
    $display("test no_fall done");
  endtask
  task automatic t_burst_wrap();
    wr(7'h00, '{8'h12, 8'h34, 8'h56});
    wr(7'h1e, '{8'h5a, 8'ha5});
    host.cpol = 1'b1;
    rd(7'h7e, 3, q);
    host.cpol = 1'b0;
    chk("bit6 alias read", 16'h5a, {8'h0, q[0]});
    chk("next byte", 16'ha5, {8'h0, q[1]});
    chk("wrap to zero", 16'h12, {8'h0, q[2]});
    chk("minutes view", 16'h56, {8'h0, time_view[2]});
    $display("test burst_wrap done");
  endtask
  task automatic t_partial();
    logic [7:0] rx;
    host.begin_frame();
    host.xfer(8'h9a, 8, rx);
    host.xfer(8'h77, 8, rx);
    host.xfer(8'hff, 4, rx);
    host.end_frame();
    rd(7'h1a, 2, q);
    chk("whole byte kept", 16'h77, {8'h0, q[0]});
    chk("cut byte dropped", 16'h00, {8'h0, q[1]});
    $display("test partial done");
  endtask
  task automatic t_supply();
    logic [7:0] rx;
    host.begin_frame();
    host.xfer(8'h9c, 8, rx);
    host.xfer(8'h11, 8, rx);
    host.xfer(8'h22, 4, rx);
    @(negedge sys_clk);
    below = 1'b1;
    above = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("blocked on low supply", 16'h1, {15'h0, blocked});
    host.xfer(8'h20, 4, rx);
    host.end_frame();
    @(negedge sys_clk);
    below = 1'b0;
    wr(7'h1d, '{8'h33});
    chk("blocked below power fail", 16'h1, {15'h0, blocked});
    @(negedge sys_clk);
    above = 1'b1;
    repeat (REC_CYCLES - 5) @(negedge sys_clk);
    chk("blocked during recovery", 16'h1, {15'h0, blocked});
    repeat (20) @(negedge sys_clk);
    chk("released after recovery", 16'h0, {15'h0, blocked});
    rd(7'h1c, 2, q);
    chk("byte before abort", 16'h11, {8'h0, q[0]});
    chk("aborted and blocked byte", 16'h00, {8'h0, q[1]});
    $display("test supply done");
  endtask
  task automatic t_rollover();
    logic [7:0] rx;
    for (int leap = 0; leap < 2; leap++) begin
      wr(7'h00, '{8'h99, 8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h02, (leap != 0) ? 8'h24 : 8'h23});
      host.begin_frame();
      host.xfer(8'h00, 8, rx);
      repeat (3) @(negedge sys_clk);
      tick = 1'b1;
      @(negedge sys_clk);
      tick = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("frozen hundredths", 16'h99, {8'h0, time_view[0]});
      host.end_frame();
      chk("hundredths roll", 16'h00, {8'h0, time_view[0]});
      chk("hours roll", 16'h00, {10'h0, time_view[3][5:0]});
      chk("date roll", (leap != 0) ? 16'h29 : 16'h01, {8'h0, time_view[5]});
      chk("month roll", (leap != 0) ? 16'h02 : 16'h03, {8'h0, time_view[6]});
    end
    $display("test rollover done");
  endtask
  // Tick held high stalls the drain: 16 bytes fill the FIFO, the 17th waits
  task automatic t_stall();
    logic [7:0] d[$];
    for (int i = 0; i < 17; i++) d.push_back(8'(8'ha0 + i));
    tick = 1'b1;
    wr(7'h08, d);
    rd(7'h08, 1, q);
    chk("stalled byte", 16'h00, {8'h0, q[0]});
    @(negedge sys_clk);
    tick = 1'b0;
    rd(7'h08, 18, q);
    for (int i = 0; i < 16; i++) chk("fifo order", {8'h0, d[i]}, {8'h0, q[i]});
    chk("holder byte", {8'h0, d[16]}, {8'h0, q[16]});
    chk("no spill", 16'h00, {8'h0, q[17]});
    $display("test stall done");
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog well above the expected run of about 60 us
  initial begin
    #400_000;
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    close_out();
  end
  initial begin
    rst         = 1'b1;
    below       = 1'b0;
    above       = 1'b1;
    tick        = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_reset_state();
    t_no_fall();
    t_burst_wrap();
    t_partial();
    t_supply();
    t_rollover();
    t_stall();
    close_out();
  end
endmodule
`default_nettype wire
